// ==== hdl/dcr_top.sv ====
// sfr front end: arm, abort, start request and config pointers
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] writing one to abort disarms every channel armed at that moment
// [R2] abort bit is only a write strobe and always reads zero
// [R3] a channel may be triggered only while its arm bit is set
// [R4] non-repeating completion clears the channel arm bit
// [R5] mode field: single, block, repeated single, repeated block
// [R6] writing one to a request bit acts as one trigger event
// [R7] request bit clears when the channel is granted access
// [R8] only clearing the arm bit stops a started channel
// [R9] channel 0 config address is high byte and low byte registers
// [R10] channels 1 to 4 share one base, high byte register
// [R11] shared base low byte is its own register, reset zero
// [R12] channels 1 to 4 configs at 8-byte steps from shared base
// [R13] unused arm and request bits read zero and ignore writes
module dcr_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  input  wire logic [4:0]  hw_trigger,
  input  wire logic [4:0]  grant,
  input  wire logic [4:0]  done,
  input  wire logic [9:0]  transfer_mode_field,
  output logic      [4:0]  chan_trigger,
  output logic      [4:0]  chan_armed,
  output logic             abort_pulse,
  output logic      [79:0] cfg_addr
);
  dcr_chan_if ch ();

  // register selects, one per mapped address
  logic        sel_shared_low;
  logic        sel_shared_high;
  logic        sel_ch0_low;
  logic        sel_ch0_high;
  logic        sel_arm;
  logic        sel_req;

  // strobes, each already qualified by the clock enable
  logic        wr_en;
  logic        rd_en;
  logic        wr_arm;
  logic        wr_req;
  logic        wr_shared_low;
  logic        wr_shared_high;
  logic        wr_ch0_low;
  logic        wr_ch0_high;

  // configuration pointer bytes and the addresses built from them
  logic [7:0]  ch0_cfg_ptr_low_q;
  logic [7:0]  ch0_cfg_ptr_high_q;
  logic [7:0]  shared_cfg_ptr_low_q;
  logic [7:0]  shared_cfg_ptr_high_q;
  logic [15:0] ch0_base;
  logic [15:0] shared_base;

  // read path and abort strobe
  logic [7:0]  arm_rd_view;
  logic [7:0]  req_rd_view;
  logic [7:0]  rdata_d;
  logic [7:0]  rdata_q;
  logic        abort_d;
  logic        abort_q;
  logic        hit_d;

  // address decode: each mapped register has a select of its own
  assign sel_shared_low  = (sfr_addr == dcr_pkg::ADDR_SHARED_LOW);
  assign sel_shared_high = (sfr_addr == dcr_pkg::ADDR_SHARED_HIGH);
  assign sel_ch0_low     = (sfr_addr == dcr_pkg::ADDR_CH0_LOW);
  assign sel_ch0_high    = (sfr_addr == dcr_pkg::ADDR_CH0_HIGH);
  assign sel_arm         = (sfr_addr == dcr_pkg::ADDR_ARM);
  assign sel_req         = (sfr_addr == dcr_pkg::ADDR_REQ);
  // the six mapped addresses; anything else reads zero, takes no write
  // kept combinational so the core can tell mapped from free addresses
  assign hit_d = sel_shared_low | sel_shared_high | sel_ch0_low |
                 sel_ch0_high | sel_arm | sel_req;

  // one enable qualifies every strobe, so a frozen cycle takes nothing
  assign wr_en          = clk_en && sfr_wr;
  assign rd_en          = clk_en && sfr_rd;
  assign wr_arm         = wr_en && sel_arm;
  assign wr_req         = wr_en && sel_req;
  assign wr_shared_low  = wr_en && sel_shared_low;
  assign wr_shared_high = wr_en && sel_shared_high;
  assign wr_ch0_low     = wr_en && sel_ch0_low;
  assign wr_ch0_high    = wr_en && sel_ch0_high;

  // [R1] a one written to bit 7 of the arm register is the abort strobe
  assign abort_d = wr_arm && sfr_wdata[dcr_pkg::ABORT_BIT];

  // [R13] only the low five bits reach the channels
  // bits 6:5 of an arm write are dropped here and never stored
  assign ch.arm_wr    = {5{wr_arm}};
  assign ch.arm_wdata = sfr_wdata[4:0];
  assign ch.abort_wr  = abort_d;
  // [R6] a written one sets a request; written zeros leave bits alone
  assign ch.req_set   = wr_req ? sfr_wdata[4:0] : dcr_pkg::CH_RESET;
  // [R7] grant and done pulses pass straight to the channel bits
  assign ch.grant     = grant;
  assign ch.done      = done;
  // [R5] mode per channel, two bits each
  assign ch.mode      = transfer_mode_field;

  // priority in the channel bits: abort, arm write, then auto clear;
  // a request set in its grant cycle survives so no start is lost
  dcr_chan_bits u_bits (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .ch      (ch)
  );

  // [R3] a trigger or request reaches the engine only while armed
  assign chan_trigger = (hw_trigger | ch.req_q) & ch.arm_q;
  assign chan_armed   = ch.arm_q;

  // four pointer bytes, each a short process of its own;
  // all reset to zero, so an unprogrammed channel 0 or 1 points at address 0
  // [R9] channel 0 pointer, low byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ch0_cfg_ptr_low_q <= dcr_pkg::CFG_RESET;
    end else if (wr_ch0_low) begin
      ch0_cfg_ptr_low_q <= sfr_wdata;
    end
  end

  // [R9] channel 0 pointer, high byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ch0_cfg_ptr_high_q <= dcr_pkg::CFG_RESET;
    end else if (wr_ch0_high) begin
      ch0_cfg_ptr_high_q <= sfr_wdata;
    end
  end

  // [R11] shared pointer, low byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shared_cfg_ptr_low_q <= dcr_pkg::CFG_RESET;
    end else if (wr_shared_low) begin
      shared_cfg_ptr_low_q <= sfr_wdata;
    end
  end

  // [R10] shared pointer, high byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shared_cfg_ptr_high_q <= dcr_pkg::CFG_RESET;
    end else if (wr_shared_high) begin
      shared_cfg_ptr_high_q <= sfr_wdata;
    end
  end

  // [R9] channel 0 structure address, high byte above low byte
  assign ch0_base       = {ch0_cfg_ptr_high_q, ch0_cfg_ptr_low_q};
  // [R10] base shared by channels 1 to 4
  assign shared_base    = {shared_cfg_ptr_high_q, shared_cfg_ptr_low_q};
  // bytes are written one at a time, so a pointer in flux is half old;
  // software should not trigger a channel between the two writes
  assign cfg_addr[15:0] = ch0_base;

  // [R12] 8-byte steps in channel order, wrapping at 64k like the pointer
  genvar k;
  generate
    for (k = 1; k < dcr_pkg::NUM_CH; k++) begin : g_cfg
      // channel k sits k-1 steps above the shared base
      assign cfg_addr[16*k +: 16] =
        16'(shared_base + 16'(dcr_pkg::CFG_STEP * 16'(k - 1)));
    end
  endgenerate

  // [R2] abort is never stored, so bit 7 of the arm view reads zero
  assign arm_rd_view = {3'h0, ch.arm_q};
  // [R13] unused request bits read zero
  // a request stays readable while unarmed, so software can see it pend
  assign req_rd_view = {3'h0, ch.req_q};

  // read select: and-or of one-hot selects, zero when nothing matches;
  // the view is taken before the edge, so a write and a read of one
  // register in the same cycle return the old byte
  assign rdata_d = ({8{sel_shared_low}}  & shared_cfg_ptr_low_q)  |
                   ({8{sel_shared_high}} & shared_cfg_ptr_high_q) |
                   ({8{sel_ch0_low}}     & ch0_cfg_ptr_low_q)     |
                   ({8{sel_ch0_high}}    & ch0_cfg_ptr_high_q)    |
                   ({8{sel_arm}}         & arm_rd_view)           |
                   ({8{sel_req}}         & req_rd_view);

  // registered read data, low between reads so stale bytes never show;
  // a frozen cycle holds the last byte
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= rd_en ? rdata_d : 8'h00;
    end
  end

  // one-cycle abort indication for the transfer engine;
  // registered so the engine sees a clean pulse one edge after the write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      abort_q <= 1'b0;
    end else if (clk_en) begin
      abort_q <= abort_d;
    end
  end

  // outputs
  assign sfr_rdata   = rdata_q;
  assign sfr_hit     = hit_d;
  assign abort_pulse = abort_q;
endmodule
`default_nettype wire

// ==== hdl/dcr_pkg.sv ====
// constants for the dma channel arm and request control block
package dcr_pkg;
  localparam int         NUM_CH           = 5;
  localparam logic [7:0] ADDR_SHARED_LOW  = 8'hD2;
  localparam logic [7:0] ADDR_SHARED_HIGH = 8'hD3;
  localparam logic [7:0] ADDR_CH0_LOW     = 8'hD4;
  localparam logic [7:0] ADDR_CH0_HIGH    = 8'hD5;
  localparam logic [7:0] ADDR_ARM         = 8'hD6;
  localparam logic [7:0] ADDR_REQ         = 8'hD7;
  localparam int         ABORT_BIT        = 7;
  localparam logic [7:0] CFG_RESET        = 8'h00;
  localparam logic [4:0] CH_RESET         = 5'h00;
  localparam logic [15:0] CFG_STEP        = 16'h0008;
  localparam logic [1:0] MODE_SINGLE      = 2'h0;
  localparam logic [1:0] MODE_BLOCK       = 2'h1;
  localparam logic [1:0] MODE_REP_SINGLE  = 2'h2;
  localparam logic [1:0] MODE_REP_BLOCK   = 2'h3;
endpackage

// ==== hdl/dcr_chan_if.sv ====
// per-channel arm and request state shared between the top and channel logic
`timescale 1ns/1ps
`default_nettype none
interface dcr_chan_if;
  logic [4:0] arm_q;
  logic [4:0] req_q;
  logic [4:0] arm_wr;
  logic [4:0] arm_wdata;
  logic       abort_wr;
  logic [4:0] req_set;
  logic [4:0] grant;
  logic [4:0] done;
  logic [9:0] mode;
  modport ctrl (output arm_wr, arm_wdata, abort_wr, req_set, grant, done,
                mode, input arm_q, req_q);
  modport chan (input arm_wr, arm_wdata, abort_wr, req_set, grant, done,
                mode, output arm_q, req_q);
endinterface
`default_nettype wire

// ==== hdl/dcr_chan_bits.sv ====
// arm and request flip-flops for every channel
`timescale 1ns/1ps
`default_nettype none
module dcr_chan_bits (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  dcr_chan_if.chan  ch
);
  genvar i;
  generate
    for (i = 0; i < dcr_pkg::NUM_CH; i++) begin : g_ch
      logic rep;
      // repeated encodings keep the channel armed after completion
      assign rep = (ch.mode[2*i +: 2] == dcr_pkg::MODE_REP_SINGLE) ||
                   (ch.mode[2*i +: 2] == dcr_pkg::MODE_REP_BLOCK);
      // arm bit: software write, abort, auto clear
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          ch.arm_q[i] <= 1'b0;
        end else if (clk_en) begin
          // [R1] abort stops armed
          if (ch.abort_wr) begin
            ch.arm_q[i] <= 1'b0;
          // [R8] zero write stops
          end else if (ch.arm_wr[i]) begin
            ch.arm_q[i] <= ch.arm_wdata[i];
          // [R4] non-repeating completion clears
          end else if (ch.done[i] && !rep) begin
            ch.arm_q[i] <= 1'b0;
          end
        end
      end
      // request bit: set wins over the grant clear so no start is lost
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          ch.req_q[i] <= 1'b0;
        end else if (clk_en) begin
          // [R6] software start request
          if (ch.req_set[i]) begin
            ch.req_q[i] <= 1'b1;
          // [R7] clear on grant
          end else if (ch.grant[i]) begin
            ch.req_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== sim/dcr_top_monitor.sv ====
// port checker for the dma arm and request control block
`timescale 1ns/1ps
`default_nettype none
module dcr_top_monitor (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  input wire logic [4:0]  done,
  input wire logic [9:0]  transfer_mode_field,
  input wire logic [4:0]  chan_trigger,
  input wire logic [4:0]  chan_armed,
  input wire logic        abort_pulse,
  input wire logic [79:0] cfg_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // taken write to the arm register
  wire logic aw = clk_en && sfr_wr && sfr_addr == 8'hD6;
  chk_trig_gated: assert property
    ((chan_trigger & ~chan_armed) == 5'h00) else $error("trigger unarmed");
  chk_abort_disarm: assert property
    (aw && sfr_wdata[7] |=> chan_armed == 5'h00 && abort_pulse)
    else $error("abort failed");
  chk_abort_cause: assert property
    (abort_pulse |-> $past(aw) && $past(sfr_wdata[7]))
    else $error("stray abort");
  chk_arm_load: assert property
    (aw && !sfr_wdata[7] |=> chan_armed == $past(sfr_wdata[4:0]))
    else $error("arm write lost");
  chk_arm_read: assert property
    (clk_en && sfr_rd && sfr_addr[7:1] == 7'h6B |=> sfr_rdata[7:5] == 3'h0)
    else $error("upper bits read");
  chk_once_done: assert property
    (clk_en && !sfr_wr && done[0] && !transfer_mode_field[1] |=>
     !chan_armed[0]) else $error("arm kept");
  chk_rep_keep: assert property
    (clk_en && !sfr_wr && done[2] && transfer_mode_field[5] && chan_armed[2]
     |=> chan_armed[2]) else $error("repeat disarmed");
  chk_shared_step: assert property
    (cfg_addr[79:64] == cfg_addr[63:48] + 16'h0008 &&
     cfg_addr[63:48] == cfg_addr[47:32] + 16'h0008 &&
     cfg_addr[47:32] == cfg_addr[31:16] + 16'h0008) else $error("bad step");
  chk_unmapped_zero: assert property
    (clk_en && sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
    else $error("unmapped data");
  cover property (aw && sfr_wdata[7]);
  cover property (done[0]);
  cover property (chan_trigger[2]);
endmodule
bind dcr_top dcr_top_monitor mon (
  .clk                 (clk),
  .reset_n             (reset_n),
  .clk_en              (clk_en),
  .sfr_addr            (sfr_addr),
  .sfr_wr              (sfr_wr),
  .sfr_rd              (sfr_rd),
  .sfr_wdata           (sfr_wdata),
  .sfr_rdata           (sfr_rdata),
  .sfr_hit             (sfr_hit),
  .done                (done),
  .transfer_mode_field (transfer_mode_field),
  .chan_trigger        (chan_trigger),
  .chan_armed          (chan_armed),
  .abort_pulse         (abort_pulse),
  .cfg_addr            (cfg_addr)
);
`default_nettype wire

// ==== sim/dcr_engine_model.sv ====
// behavioural transfer engine: grants a triggered channel, completes later
`timescale 1ns/1ps
`default_nettype none
module dcr_engine_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       slow,
  input  wire logic [4:0] chan_trigger,
  output logic      [4:0] grant,
  output logic      [4:0] done
);
  logic [4:0] act_q;
  logic [3:0] cnt_q;
  // one transfer at a time, lowest channel first; busy hides the trigger
  // started transfer runs on
  always_ff @(posedge clk) begin
    grant <= 5'h00;
    done <= 5'h00;
    if (!reset_n) cnt_q <= 4'h0;
    else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) done <= act_q;
    end else if (chan_trigger != 5'h00) begin
      act_q <= chan_trigger & (~chan_trigger + 5'h01);
      grant <= chan_trigger & (~chan_trigger + 5'h01);
      cnt_q <= slow ? 4'h8 : 4'h2;
    end
  end
endmodule
`default_nettype wire

// ==== sim/dcr_top_tb_top.sv ====
// self-checking bench for the dma arm and request control block
`timescale 1ns/1ps
`default_nettype none
module dcr_top_tb_top;
  logic        clk, sfr_hit, abort_pulse;
  logic        reset_n = 1'b0, clk_en = 1'b1, slow = 1'b0;
  logic        sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [4:0]  hw_trigger = 5'h00, grant, done, chan_trigger, chan_armed;
  logic [9:0]  transfer_mode_field = 10'h034;
  logic [79:0] cfg_addr;
  int          miscompares = 0, n_compared = 0;
  dcr_top dut (
    .clk                 (clk),
    .reset_n             (reset_n),
    .clk_en              (clk_en),
    .sfr_addr            (sfr_addr),
    .sfr_wr              (sfr_wr),
    .sfr_rd              (sfr_rd),
    .sfr_wdata           (sfr_wdata),
    .sfr_rdata           (sfr_rdata),
    .sfr_hit             (sfr_hit),
    .hw_trigger          (hw_trigger),
    .grant               (grant),
    .done                (done),
    .transfer_mode_field (transfer_mode_field),
    .chan_trigger        (chan_trigger),
    .chan_armed          (chan_armed),
    .abort_pulse         (abort_pulse),
    .cfg_addr            (cfg_addr)
  );
  dcr_engine_model eng (
    .clk          (clk),
    .reset_n      (reset_n),
    .slow         (slow),
    .chan_trigger (chan_trigger),
    .grant        (grant),
    .done         (done)
  );
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [79:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) #10 sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clk) #10 sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk) #10 sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge clk) #10 sfr_rd = 1'b0;
    chk(sfr_rdata, exp, "rdata");
  endtask
  // bounded wait for completion; running out ends the run
  task automatic wait_done(input int i);
    int k;
    for (k = 0; k < 40 && done[i] !== 1'b1; k++) @(posedge clk) #1;
    if (k == 40) begin
      miscompares++;
      summarize();
    end
  endtask
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task t_regs;
    for (int a = 8'hD1; a <= 8'hD7; a++) begin
      rd(a[7:0], 8'h00);
      chk(sfr_hit, a >= 8'hD2, "hit");
    end
    wr(8'hD5, 8'h12);
    wr(8'hD4, 8'h34);
    wr(8'hD3, 8'h56);
    wr(8'hD2, 8'h78);
    rd(8'hD2, 8'h78);
    chk(cfg_addr[15:0], 16'h1234, "ch0 cfg");
    chk(cfg_addr[31:16], 16'h5678, "ch1 cfg");
    chk(cfg_addr[79:64], 16'h5690, "ch4 cfg");
    $display("test regs done");
  endtask
  task t_abort;
    wr(8'hD6, 8'h7F);
    rd(8'hD6, 8'h1F);
    wr(8'hD6, 8'h80);
    rd(8'hD6, 8'h00);
    wr(8'hD7, 8'hE0);
    rd(8'hD7, 8'h00);
    $display("test abort done");
  endtask
  // a write while the clock enable is low must leave the channel unarmed
  task t_hold;
    @(posedge clk) #10 clk_en = 1'b0;
    wr(8'hD6, 8'h01);
    chk(chan_armed, 5'h00, "frozen arm");
    @(posedge clk) #10 clk_en = 1'b1;
    rd(8'hD6, 8'h00);
    $display("test hold done");
  endtask
  // channel 0 in single mode: request pends, arming starts it
  task t_single;
    wr(8'hD7, 8'h01);
    wr(8'hD6, 8'h01);
    wait_done(0);
    rd(8'hD6, 8'h00);
    rd(8'hD7, 8'h00);
    $display("test single done");
  endtask
  task t_req;
    wr(8'hD7, 8'h02);
    rd(8'hD7, 8'h02);
    chk(chan_trigger, 5'h00, "unarmed trigger");
    wr(8'hD6, 8'h02);
    wait_done(1);
    rd(8'hD6, 8'h00);
    rd(8'hD7, 8'h00);
    $display("test request done");
  endtask
  task t_rep;
    slow = 1'b1;
    wr(8'hD6, 8'h04);
    @(posedge clk) #10 hw_trigger = 5'h04;
    @(posedge clk) #10 hw_trigger = 5'h00;
    wait_done(2);
    rd(8'hD6, 8'h04);
    wr(8'hD6, 8'h00);
    rd(8'hD6, 8'h00);
    $display("test repeat done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clk);
    #10 reset_n = 1'b1;
    t_regs();
    t_abort();
    t_hold();
    t_single();
    t_req();
    t_rep();
    summarize();
  end
endmodule
`default_nettype wire
